// ==== branch_mul_exec.sv ====
// Execution unit for increment, test, clear, multiply, jump, call, return, compare,
// skip and conditional branch instructions; owns the program counter and flag word.
// Assumes decode presents one request at a time and that stack_top holds the return
// address to pop in the cycle a return is taken.
// Functional notes
// - Increment, decrement, self-AND test in one cycle; only Z, N, V change.
// - Clear is XOR with itself, flags Z N V; fill ones touches no flag.
// - Integer multiplies put 16-bit product in r1:r0, set Z and C, two cycles.
// - Fractional multiplies store product shifted left one, set Z and C, two cycles.
// - Relative goto to pc+k+1 or pointer goto: two cycles; absolute goto three.
// - Relative/pointer calls three, direct four cycles, push return; returns four cycles.
// - Equal compare skips next instruction, pc+2 or +3, no flags, 1/2/3 cycles.
// - Skip next on register bit zero or one, no flags, 1/2/3 cycles.
// - Skip next on I/O register bit zero or one, no flags, 1/2/3 cycles.
// - Generic branch tests one flag word bit; taken pc+k+1 in 2, else 1.
// - Unsigned ge/lt branches act as carry clear/set branches, 1 or 2 cycles.
// - Signed ge branch taken when N xor V is zero; 1 or 2 cycles.
// - Half-carry one/zero branches add k+1 when taken, 1 or 2 cycles.
// - Transfer bit one/zero branches add k+1 when taken, 1 or 2 cycles.
// - Overflow one/zero branches add k+1 when taken, flags untouched.
module branch_mul_exec (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request
  input wire logic req_valid,
  input wire exec_pkg::req_s req,
  output logic req_ready,
  // Completion
  output logic done,
  // Register write-back
  output exec_pkg::wb_s wb_ff,
  // Flag word
  input wire logic flag_ext_we,
  input wire logic [7:0] flag_ext_data,
  output logic [7:0] flags_ff,
  // Program counter
  output logic [exec_pkg::PC_W-1:0] pc_ff,
  // Stack
  input wire logic [exec_pkg::PC_W-1:0] stack_top,
  output logic push_en,
  output logic [exec_pkg::PC_W-1:0] push_pc,
  output logic pop_en
);
  import exec_pkg::*;

  logic [2:0] wait_ff;
  logic [2:0] nxt_wait;
  logic take;
  logic [PC_W-1:0] nxt_pc;
  logic [7:0] nxt_flags;
  wb_s nxt_wb;
  logic nxt_push;
  logic [PC_W-1:0] nxt_push_pc;
  logic nxt_pop;
  logic [15:0] prod;
  logic prod_c;
  logic prod_z;
  mul_mode_e mmode;
  logic mfrac;

  function automatic logic [PC_W-1:0] pc_add(input logic [PC_W-1:0] pc,
                                             input logic [PC_W-1:0] step);
    pc_add = PC_W'(pc + step);
  endfunction : pc_add

  function automatic logic [PC_W-1:0] pc_rel(input logic [PC_W-1:0] pc,
                                             input logic [OFS_W-1:0] k);
    pc_rel = PC_W'(pc + {{(PC_W-OFS_W){k[OFS_W-1]}}, k} + PC_STEP_1);
  endfunction : pc_rel

  // Skip target and cycle count; both depend on the skipped word count
  function automatic logic [PC_W-1:0] skip_pc(input logic [PC_W-1:0] pc, input logic cond,
                                              input logic two);
    skip_pc = !cond ? pc_add(pc, PC_STEP_1) : (two ? pc_add(pc, PC_STEP_3)
                                                   : pc_add(pc, PC_STEP_2));
  endfunction : skip_pc

  function automatic logic [2:0] skip_cyc(input logic cond, input logic two);
    skip_cyc = !cond ? 3'(CYC_1) : (two ? 3'(CYC_3) : 3'(CYC_2));
  endfunction : skip_cyc

  // Condition of every branch form, from the flag word
  function automatic logic branch_cond(input op_e op, input logic [7:0] f,
                                       input logic [2:0] s);
    case (op)
      branch_flag_one: branch_cond = f[s];
      branch_flag_zero: branch_cond = !f[s];
      branch_on_equal: branch_cond = f[FLAG_Z];
      branch_on_unequal: branch_cond = !f[FLAG_Z];
      branch_carry_one, branch_unsigned_lt: branch_cond = f[FLAG_C];
      branch_carry_zero, branch_unsigned_ge: branch_cond = !f[FLAG_C];
      branch_negative: branch_cond = f[FLAG_N];
      branch_nonnegative: branch_cond = !f[FLAG_N];
      branch_signed_ge: branch_cond = !(f[FLAG_N] ^ f[FLAG_V]);
      branch_signed_lt: branch_cond = f[FLAG_N] ^ f[FLAG_V];
      branch_halfcarry_one: branch_cond = f[FLAG_H];
      branch_halfcarry_zero: branch_cond = !f[FLAG_H];
      branch_transfer_bit_one: branch_cond = f[FLAG_T];
      branch_transfer_bit_zero: branch_cond = !f[FLAG_T];
      branch_overflow_one: branch_cond = f[FLAG_V];
      branch_overflow_zero: branch_cond = !f[FLAG_V];
      default: branch_cond = 1'b0;
    endcase
  endfunction : branch_cond

  assign req_ready = (wait_ff == 3'd0);
  assign take = req_valid && req_ready;
  // Completion marks the last cycle of the instruction
  assign done = (wait_ff == 3'd1) || (take && nxt_wait == 3'(CYC_1));

  always_comb begin
    mfrac = 1'b0;
    case (req.op)
      product_signed_op: mmode = mul_ss;
      product_mixed_op: mmode = mul_su;
      q_product_unsigned_op: begin
        mmode = mul_uu;
        mfrac = 1'b1;
      end
      q_product_signed_op: begin
        mmode = mul_ss;
        mfrac = 1'b1;
      end
      q_product_mixed_op: begin
        mmode = mul_su;
        mfrac = 1'b1;
      end
      default: mmode = mul_uu;
    endcase
  end

  mul_unit u_mul (
    .a(req.rd),
    .b(req.rr),
    .mode(mmode),
    .frac(mfrac),
    .product(prod),
    .carry(prod_c),
    .zero(prod_z)
  );

  always_comb begin
    logic [7:0] res;
    logic [8:0] diff;
    logic [4:0] hdiff;
    logic cin;
    logic cond;
    res = BYTE_ZERO;
    diff = 9'h000;
    hdiff = 5'h00;
    cin = 1'b0;
    cond = 1'b0;
    nxt_pc = pc_add(pc_ff, PC_STEP_1);
    nxt_flags = flags_ff;
    nxt_wb = '0;
    nxt_push = 1'b0;
    nxt_push_pc = PC_RST;
    nxt_pop = 1'b0;
    nxt_wait = 3'(CYC_1);
    case (req.op)
      inc_op, dec_op, self_and_test_op, zero_register_op: begin
        case (req.op)
          inc_op: res = 8'(req.rd + 8'h01);
          dec_op: res = 8'(req.rd - 8'h01);
          self_and_test_op: res = req.rd & req.rd;
          default: res = req.rd ^ req.rd;
        endcase
        nxt_wb.rd_we = (req.op != self_and_test_op);
        nxt_wb.rd_data = res;
        nxt_flags[FLAG_Z] = (res == BYTE_ZERO);
        nxt_flags[FLAG_N] = res[7];
        nxt_flags[FLAG_V] = (req.op == inc_op) ? (res == BYTE_MIN_NEG) :
                            (req.op == dec_op) ? (res == BYTE_MAX_POS) : 1'b0;
      end
      fill_ones_op: begin
        nxt_wb.rd_we = 1'b1;
        nxt_wb.rd_data = BYTE_ONES;
      end
      product_unsigned_op, product_signed_op, product_mixed_op,
      q_product_unsigned_op, q_product_signed_op, q_product_mixed_op: begin
        nxt_wb.pair_we = 1'b1;
        nxt_wb.pair_hi = prod[15:8];
        nxt_wb.pair_lo = prod[7:0];
        nxt_flags[FLAG_Z] = prod_z;
        nxt_flags[FLAG_C] = prod_c;
        nxt_wait = 3'(CYC_2);
      end
      pc_relative_goto: begin
        nxt_pc = pc_rel(pc_ff, req.ofs);
        nxt_wait = 3'(CYC_2);
      end
      pointer_goto: begin
        nxt_pc = req.z_ptr;
        nxt_wait = 3'(CYC_2);
      end
      absolute_goto: begin
        nxt_pc = req.target;
        nxt_wait = 3'(CYC_3);
      end
      pc_relative_subroutine_entry, pointer_subroutine_entry: begin
        nxt_pc = (req.op == pointer_subroutine_entry) ? req.z_ptr : pc_rel(pc_ff, req.ofs);
        nxt_push = 1'b1;
        nxt_push_pc = pc_add(pc_ff, PC_STEP_1);
        nxt_wait = 3'(CYC_3);
      end
      absolute_subroutine_entry: begin
        nxt_pc = req.target;
        nxt_push = 1'b1;
        nxt_push_pc = pc_add(pc_ff, PC_STEP_2); // Two-word call
        nxt_wait = CYC_4;
      end
      subroutine_exit, handler_exit: begin
        nxt_pc = stack_top;
        nxt_pop = 1'b1;
        nxt_wait = CYC_4;
        if (req.op == handler_exit) begin
          nxt_flags[FLAG_I] = 1'b1;
        end
      end
      equal_compare_skip, skip_reg_bit_zero, skip_reg_bit_one,
      skip_io_bit_zero, skip_io_bit_one: begin
        case (req.op)
          equal_compare_skip: cond = (req.rd == req.rr);
          skip_reg_bit_zero: cond = !req.rr[req.bit_sel];
          skip_reg_bit_one: cond = req.rr[req.bit_sel];
          skip_io_bit_zero: cond = !req.io_val[req.bit_sel];
          default: cond = req.io_val[req.bit_sel];
        endcase
        nxt_pc = skip_pc(pc_ff, cond, req.next_two_word);
        nxt_wait = skip_cyc(cond, req.next_two_word);
      end
      compare_op, compare_borrow_op, compare_constant_op: begin
        cin = (req.op == compare_borrow_op) && flags_ff[FLAG_C];
        diff = 9'({1'b0, req.rd} - {1'b0, req.rr} - 9'(cin));
        hdiff = 5'({1'b0, req.rd[3:0]} - {1'b0, req.rr[3:0]} - 5'(cin));
        res = diff[7:0];
        nxt_flags[FLAG_C] = diff[8];
        nxt_flags[FLAG_H] = hdiff[4];
        nxt_flags[FLAG_N] = res[7];
        nxt_flags[FLAG_V] = (req.rd[7] & ~req.rr[7] & ~res[7]) |
                            (~req.rd[7] & req.rr[7] & res[7]);
        // With borrow, zero only holds if the earlier bytes were zero too
        nxt_flags[FLAG_Z] = (res == BYTE_ZERO) &&
                            ((req.op != compare_borrow_op) || flags_ff[FLAG_Z]);
      end
      default: begin
        cond = branch_cond(req.op, flags_ff, req.bit_sel);
        if (cond) begin
          nxt_pc = pc_rel(pc_ff, req.ofs);
          nxt_wait = 3'(CYC_2);
        end
      end
    endcase
  end

  // Busy countdown, holding off the next request until the count runs out
  always_ff @(posedge clk) begin
    if (rst) begin
      wait_ff <= 3'd0;
    end else if (take) begin
      wait_ff <= 3'(nxt_wait - 3'd1);
    end else if (wait_ff != 3'd0) begin
      wait_ff <= 3'(wait_ff - 3'd1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pc_ff <= PC_RST;
    end else if (take) begin
      pc_ff <= nxt_pc;
    end
  end

  // Unit's own update wins over an external write in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      flags_ff <= FLAGS_RST;
    end else if (take) begin
      flags_ff <= nxt_flags;
    end else if (flag_ext_we) begin
      flags_ff <= flag_ext_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wb_ff <= '0;
      push_en <= 1'b0;
      push_pc <= PC_RST;
      pop_en <= 1'b0;
    end else begin
      wb_ff <= take ? nxt_wb : '0;
      push_en <= take && nxt_push;
      push_pc <= take ? nxt_push_pc : push_pc;
      pop_en <= take && nxt_pop;
    end
  end

endmodule : branch_mul_exec

// ==== branch_mul_exec_monitor.sv ====
// Concurrent checks on the execution unit: flags, products, flow timing, stack.
// Assumes it is bound into branch_mul_exec and sees only that module's ports.
module branch_mul_exec_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request
  input wire logic req_valid,
  input wire exec_pkg::req_s req,
  input wire logic req_ready,
  // Results
  input wire logic done,
  input wire exec_pkg::wb_s wb_ff,
  input wire logic [7:0] flags_ff,
  input wire logic [exec_pkg::PC_W-1:0] pc_ff,
  // Stack
  input wire logic [exec_pkg::PC_W-1:0] stack_top,
  input wire logic push_en,
  input wire logic [exec_pkg::PC_W-1:0] push_pc,
  input wire logic pop_en
);
  import exec_pkg::*;
  logic take;
  logic [PC_W-1:0] rel;
  assign take = req_valid && req_ready;
  assign rel = pc_ff + {{(PC_W-OFS_W){req.ofs[OFS_W-1]}}, req.ofs} + PC_STEP_1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  inc_ovf_a: assert property (take && req.op == inc_op
    |=> wb_ff.rd_data == $past(req.rd) + 8'h01 && flags_ff[FLAG_V] == (wb_ff.rd_data == 8'h80))
    else $error("increment result or overflow wrong");
  fill_flags_a: assert property (take && req.op == fill_ones_op
    |=> wb_ff.rd_data == BYTE_ONES && flags_ff == $past(flags_ff))
    else $error("fill wrote wrong value or touched flags");
  mul_two_cyc_a: assert property (take && req.op inside {[product_unsigned_op:q_product_mixed_op]}
    |=> wb_ff.pair_we && !req_ready ##1 req_ready)
    else $error("multiply not two cycles");
  abs_goto_a: assert property (take && req.op == absolute_goto
    |=> pc_ff == $past(req.target) ##0 (!req_ready) [*2] ##1 req_ready)
    else $error("absolute goto target or timing wrong");
  rel_call_a: assert property (take && req.op == pc_relative_subroutine_entry
    |=> push_en && push_pc == $past(pc_ff) + 16'h0001 && pc_ff == $past(rel))
    else $error("relative call push or target wrong");
  ret_four_a: assert property (take && req.op == subroutine_exit
    |=> pop_en && pc_ff == $past(stack_top) ##0 (!req_ready) [*3] ##1 req_ready)
    else $error("return target or timing wrong");
  skip_flags_a: assert property (take && req.op inside {equal_compare_skip, [skip_reg_bit_zero:skip_io_bit_one]}
    |=> flags_ff == $past(flags_ff))
    else $error("skip changed flags");
  signed_ge_a: assert property (take && req.op == branch_signed_ge && !(flags_ff[FLAG_N] ^ flags_ff[FLAG_V])
    |=> pc_ff == $past(rel))
    else $error("signed ge branch not taken");
  signed_lt_a: assert property (take && req.op == branch_signed_lt && (flags_ff[FLAG_N] ^ flags_ff[FLAG_V])
    |=> pc_ff == $past(rel))
    else $error("signed lt branch not taken");
  ovf_fall_a: assert property (take && req.op == branch_overflow_zero && flags_ff[FLAG_V]
    |=> pc_ff == $past(pc_ff) + 16'h0001 && req_ready)
    else $error("untaken overflow branch wrong");
  done_single_a: assert property (take && req.op inside {[inc_op:fill_ones_op]}
    |-> done)
    else $error("one-cycle op without completion");
  call_done_a: assert property (take && req.op == absolute_subroutine_entry
    |-> !done ##1 (!done) [*2] ##1 done)
    else $error("direct call completion not in fourth cycle");

  mul_c: cover property (take && req.op == q_product_mixed_op);
  call_c: cover property (take && req.op == absolute_subroutine_entry);
  exit_c: cover property (take && req.op == handler_exit);
endmodule : branch_mul_exec_monitor

bind branch_mul_exec branch_mul_exec_monitor i_mon (.clk(clk), .rst(rst), .req_valid(req_valid),
  .req(req), .req_ready(req_ready), .done(done), .wb_ff(wb_ff), .flags_ff(flags_ff), .pc_ff(pc_ff),
  .stack_top(stack_top), .push_en(push_en), .push_pc(push_pc), .pop_en(pop_en));

// ==== branch_mul_exec_tb_top.sv ====
// Self-checking bench for branch_mul_exec: flags, products, flow, skips, branches.
// Assumes the monitor is compiled first; inputs change on the falling edge.
module branch_mul_exec_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import exec_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  req_s req = '0;
  logic req_ready, done, push_en, pop_en, lpush, lpop;
  wb_s wb_ff, lwb;
  logic flag_ext_we = 1'b0;
  logic [7:0] flag_ext_data = 8'h00;
  logic [7:0] flags_ff, ncyc, ldone;
  logic [PC_W-1:0] pc_ff, push_pc, lpc, p;
  logic [PC_W-1:0] stack_top = 16'h0000;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;

  always #2 clk = ~clk;

  branch_mul_exec i_dut (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .done(done), .wb_ff(wb_ff), .flag_ext_we(flag_ext_we),
    .flag_ext_data(flag_ext_data), .flags_ff(flags_ff), .pc_ff(pc_ff), .stack_top(stack_top),
    .push_en(push_en), .push_pc(push_pc), .pop_en(pop_en));

  task automatic give_verdict();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  // Whole run needs under two hundred cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic chk_b(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error t=%0t byte %h expected %h", $time, got, exp);
    end
  endtask : chk_b

  task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error t=%0t word %h expected %h", $time, got, exp);
    end
  endtask : chk_w

  // One-cycle outputs are caught at the first falling edge after the take
  task automatic send();
    @(negedge clk);
    req_valid = 1'b1;
    // Completion of a one-cycle op shows in the take cycle itself
    #1 ldone = (done === 1'b1) ? 8'h01 : 8'h00;
    @(negedge clk);
    req_valid = 1'b0;
    lwb = wb_ff;
    lpush = push_en;
    lpop = pop_en;
    lpc = push_pc;
    ncyc = 8'h01;
    while (req_ready !== 1'b1 && ncyc < 8'h09) begin
      if (done === 1'b1) ldone = 8'(ncyc + 8'h01);
      @(negedge clk);
      ncyc++;
    end
    chk_b(ldone, ncyc);
  endtask : send

  task automatic setf(input logic [7:0] f);
    @(negedge clk);
    flag_ext_we = 1'b1;
    flag_ext_data = f;
    @(negedge clk);
    flag_ext_we = 1'b0;
  endtask : setf

  task automatic t_alu();
    op_e o[5] = '{inc_op, dec_op, self_and_test_op, zero_register_op, fill_ones_op};
    logic [7:0] v[5] = '{8'h7F, 8'h01, 8'h80, 8'h5A, 8'h00};
    logic [7:0] r[5] = '{8'h80, 8'h00, 8'h80, 8'h00, 8'hFF};
    logic [7:0] f[5] = '{8'hFD, 8'hF3, 8'hF5, 8'hF3, 8'hF3};
    setf(8'hF1);
    foreach (o[i]) begin
      req.op = o[i];
      req.rd = v[i];
      send();
      chk_b(flags_ff, f[i]);
      chk_b(ncyc, 8'h01);
      if (i != 2) chk_b(lwb.rd_data, r[i]);
      chk_b(8'(lwb.rd_we), 8'(i != 2));
    end
    $display("alu scenario finished");
  endtask : t_alu

  task automatic t_mul();
    op_e o[6] = '{product_unsigned_op, product_signed_op, product_mixed_op,
      q_product_unsigned_op, q_product_signed_op, q_product_mixed_op};
    logic [15:0] m[6] = '{16'h7F80, 16'h0080, 16'h8080, 16'hFF00, 16'h0100, 16'h0100};
    logic [7:0] f[6] = '{8'hF0, 8'hF0, 8'hF1, 8'hF0, 8'hF0, 8'hF1};
    req.rd = 8'h80;
    req.rr = 8'hFF;
    foreach (o[i]) begin
      req.op = o[i];
      send();
      chk_w({lwb.pair_hi, lwb.pair_lo}, m[i]);
      chk_b(flags_ff, f[i]);
      chk_b(ncyc, 8'h02);
    end
    $display("multiply scenario finished");
  endtask : t_mul

  task automatic t_flow();
    op_e o[8] = '{absolute_goto, pc_relative_goto, pointer_goto, pc_relative_subroutine_entry,
      pointer_subroutine_entry, absolute_subroutine_entry, subroutine_exit, handler_exit};
    logic [15:0] a[8] = '{16'h0ABC, 16'h0000, 16'h1234, 16'h0000, 16'h2000, 16'h3000,
      16'h0555, 16'h0777};
    logic [15:0] e[8] = '{16'h0ABC, 16'h0ABB, 16'h1234, 16'h1233, 16'h2000, 16'h3000,
      16'h0555, 16'h0777};
    logic [15:0] s[8] = '{16'h0000, 16'h0000, 16'h0000, 16'h1235, 16'h1234, 16'h2002,
      16'h0000, 16'h0000};
    logic [7:0] n[8] = '{8'h03, 8'h02, 8'h02, 8'h03, 8'h03, 8'h04, 8'h04, 8'h04};
    setf(8'h00);
    req.ofs = 12'hFFE;
    foreach (o[i]) begin
      req.op = o[i];
      req.target = a[i];
      req.z_ptr = a[i];
      stack_top = a[i];
      send();
      chk_w(pc_ff, e[i]);
      chk_b(ncyc, n[i]);
      chk_w(lpush ? lpc : 16'h0000, s[i]);
      chk_b(8'(lpop), 8'(i > 5));
    end
    chk_b(flags_ff, 8'h80);
    $display("flow scenario finished");
  endtask : t_flow

  task automatic t_skip();
    op_e o[6] = '{equal_compare_skip, equal_compare_skip, skip_reg_bit_zero, skip_reg_bit_one,
      skip_io_bit_one, skip_io_bit_zero};
    logic [7:0] r[6] = '{8'h33, 8'h34, 8'hF7, 8'hF7, 8'h00, 8'h00};
    logic [7:0] st[6] = '{8'h02, 8'h01, 8'h03, 8'h01, 8'h02, 8'h01};
    logic [0:5] tw = 6'h0C;
    setf(8'h5A);
    req.rd = 8'h33;
    req.io_val = 8'h08;
    req.bit_sel = 3'h3;
    foreach (o[i]) begin
      p = pc_ff;
      req.op = o[i];
      req.rr = r[i];
      req.next_two_word = tw[i];
      send();
      chk_w(pc_ff, p + {8'h00, st[i]});
      chk_b(ncyc, st[i]);
      chk_b(flags_ff, 8'h5A);
    end
    $display("skip scenario finished");
  endtask : t_skip

  task automatic t_br();
    op_e o[20] = '{branch_flag_one, branch_flag_zero, branch_on_equal, branch_on_unequal,
      branch_carry_one, branch_carry_zero, branch_unsigned_ge, branch_unsigned_lt,
      branch_negative, branch_nonnegative, branch_signed_ge, branch_signed_lt,
      branch_signed_ge, branch_signed_lt, branch_halfcarry_one, branch_halfcarry_zero,
      branch_transfer_bit_one, branch_transfer_bit_zero, branch_overflow_one,
      branch_overflow_zero};
    logic [7:0] fl[20] = '{8'h40, 8'h40, 8'h02, 8'h02, 8'h01, 8'h01, 8'h00, 8'h00, 8'h04,
      8'h04, 8'h0C, 8'h0C, 8'h04, 8'h08, 8'h20, 8'h20, 8'h40, 8'h00, 8'h08, 8'h08};
    logic [0:19] tk = 20'hAAA6E;
    req.ofs = 12'h010;
    req.bit_sel = 3'h6;
    foreach (o[i]) begin
      setf(fl[i]);
      p = pc_ff;
      req.op = o[i];
      send();
      chk_w(pc_ff, p + (tk[i] ? 16'h0011 : 16'h0001));
      chk_b(ncyc, tk[i] ? 8'h02 : 8'h01);
      chk_b(flags_ff, fl[i]);
    end
    $display("branch scenario finished");
  endtask : t_br

  task automatic t_cmp();
    op_e o[3] = '{compare_op, compare_constant_op, compare_borrow_op};
    logic [7:0] d[3] = '{8'h10, 8'h80, 8'h05};
    logic [7:0] r[3] = '{8'h20, 8'h01, 8'h05};
    logic [7:0] f[3] = '{8'h05, 8'h28, 8'h00};
    setf(8'h00);
    foreach (o[i]) begin
      req.op = o[i];
      req.rd = d[i];
      req.rr = r[i];
      send();
      chk_b(flags_ff, f[i]);
      chk_b({6'h00, lwb.rd_we, lwb.pair_we}, 8'h00);
      chk_b(ncyc, 8'h01);
    end
    $display("compare scenario finished");
  endtask : t_cmp

  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    chk_w(pc_ff, PC_RST);
    chk_b(flags_ff, FLAGS_RST);
    t_alu();
    t_mul();
    t_flow();
    t_skip();
    t_br();
    t_cmp();
    give_verdict();
  end
endmodule : branch_mul_exec_tb_top

// ==== exec_pkg.sv ====
// Shared types and constants for the branch, multiply and increment execution unit.
// Assumes an 8-bit core with a 16-bit word program counter.
package exec_pkg;

  localparam int PC_W = 16;
  localparam int OFS_W = 12;

  // Flag word bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 16'h0000;
  localparam logic [7:0] BYTE_ONES = 8'hFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_MIN_NEG = 8'h80;
  localparam logic [7:0] BYTE_MAX_POS = 8'h7F;

  // Cycle counts
  localparam logic [1:0] CYC_1 = 2'd1;
  localparam logic [1:0] CYC_2 = 2'd2;
  localparam logic [1:0] CYC_3 = 2'd3;
  localparam logic [2:0] CYC_4 = 3'd4;

  // Program counter steps
  localparam logic [PC_W-1:0] PC_STEP_1 = 16'h0001;
  localparam logic [PC_W-1:0] PC_STEP_2 = 16'h0002;
  localparam logic [PC_W-1:0] PC_STEP_3 = 16'h0003;

  typedef enum logic [5:0] {
    inc_op, dec_op, self_and_test_op, zero_register_op, fill_ones_op,
    product_unsigned_op, product_signed_op, product_mixed_op,
    q_product_unsigned_op, q_product_signed_op, q_product_mixed_op,
    pc_relative_goto, pointer_goto, absolute_goto,
    pc_relative_subroutine_entry, pointer_subroutine_entry, absolute_subroutine_entry,
    subroutine_exit, handler_exit,
    equal_compare_skip, compare_op, compare_borrow_op, compare_constant_op,
    skip_reg_bit_zero, skip_reg_bit_one, skip_io_bit_zero, skip_io_bit_one,
    branch_flag_one, branch_flag_zero, branch_on_equal, branch_on_unequal,
    branch_carry_one, branch_carry_zero, branch_unsigned_ge, branch_unsigned_lt,
    branch_negative, branch_nonnegative, branch_signed_ge, branch_signed_lt,
    branch_halfcarry_one, branch_halfcarry_zero,
    branch_transfer_bit_one, branch_transfer_bit_zero,
    branch_overflow_one, branch_overflow_zero
  } op_e;

  typedef enum logic [1:0] {
    mul_uu, mul_ss, mul_su
  } mul_mode_e;

  // One decoded instruction
  typedef struct packed {
    op_e op;
    logic [7:0] rd;          // Destination / first operand value
    logic [7:0] rr;          // Second operand or immediate
    logic [7:0] io_val;      // Addressed I/O register value
    logic [2:0] bit_sel;     // Bit index for skips and generic branch
    logic [OFS_W-1:0] ofs;   // Signed relative offset
    logic [PC_W-1:0] target; // Absolute address
    logic [PC_W-1:0] z_ptr;  // Z pointer value
    logic next_two_word;     // Following instruction is two words long
  } req_s;

  // Register file write-back
  typedef struct packed {
    logic rd_we;
    logic [7:0] rd_data;
    logic pair_we;
    logic [7:0] pair_hi;     // Register 1
    logic [7:0] pair_lo;     // Register 0
  } wb_s;

endpackage : exec_pkg

// ==== mul_unit.sv ====
// 8x8 multiplier with unsigned, signed and mixed modes and an optional fractional shift.
// Assumes operands are stable while the caller samples the result.
module mul_unit (
  // Operands
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire exec_pkg::mul_mode_e mode,
  input wire logic frac,
  // Result
  output logic [15:0] product,
  output logic carry,
  output logic zero
);
  import exec_pkg::*;

  logic signed [17:0] ext_a;
  logic signed [17:0] ext_b;
  logic signed [17:0] raw;

  always_comb begin
    ext_a = (mode == mul_uu) ? $signed({10'h000, a}) : $signed({{10{a[7]}}, a});
    ext_b = (mode == mul_ss) ? $signed({{10{b[7]}}, b}) : $signed({10'h000, b});
    raw = 18'(ext_a * ext_b);
    // Carry is the raw bit 15, taken before the fractional shift
    carry = raw[15];
    product = frac ? {raw[14:0], 1'b0} : raw[15:0];
    zero = (product == 16'h0000);
  end

endmodule : mul_unit
